// ---- rtl/interrupt_enable_wakeup_gating.sv ----
// Function
// - PWM request needs channel and group enable
// - Pin 0 disabled: no request, no wake
// - Pin 0 enabled: event wakes; it requests only with the global enable set
// - Pin wake ignores the global enable
// - Events set flags regardless of enables
// - Equal level waits; higher level preempts
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`include "irq_gate_cfg.svh"
module interrupt_enable_wakeup_gating
  import irq_gate_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int NSRC   = 8
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              ext_pin0_n,
  input  wire logic              ext_pin1_n,
  input  wire periph_evt_t       periph_evt,
  input  wire logic              pwm_group_irq_en,
  input  wire logic              core_ack,
  input  wire logic              core_ret,
  output core_req_t              core_req,
  output logic                   wake_req,
  output logic                   irq
);

  // Register state
  logic [7:0]        base_en_reg;
  logic [7:0]        pwm_en_reg;
  logic [NSRC-1:0]   flag_reg;
  logic [NSRC-1:0]   flag_next;
  logic [NSRC-1:0]   mask_reg;
  logic [2*NSRC-1:0] prio_reg;
  logic [3:0]        active_reg;
  logic [3:0]        active_next;
  logic [2:0]        taken_idx_reg;

  // Sources whose flag the core clears by taking the request
  localparam logic [NSRC-1:0] HW_CLEAR_BITS = NSRC'(`HW_CLEAR_MASK);

  // Bus decode
  logic        setup_phase;
  logic        access_phase;
  logic        wr_access;
  logic        addr_hit;
  logic [31:0] rd_value;

  // Pin path
  logic [1:0] pin_sync;
  logic [1:0] pin_prev_reg;
  logic [1:0] pin_fall;

  // Gating
  logic [NSRC-1:0] src_event;
  logic [NSRC-1:0] src_enable;
  logic [NSRC-1:0] pending;
  logic            global_irq_en;
  logic            ext_pin0_irq_wake_en;
  logic            ext_pin1_irq_wake_en;
  logic            timer0_irq_en;
  logic            timer1_irq_en;
  logic            timer2_irq_en;
  logic            serial1_irq_en;
  logic            pwm_ch0_irq_en;
  logic            pwm_ch1_irq_en;

  // Arbitration
  logic       sel_any;
  logic [2:0] sel_idx;
  logic [1:0] sel_level;
  logic       cur_any;
  logic [1:0] cur_level;
  logic       preempt_ok;
  logic [3:0] sel_num;

  assign setup_phase  = psel && !penable;
  assign access_phase = psel && penable;
  assign wr_access    = access_phase && pwrite;
  assign pready       = access_phase;

  assign global_irq_en        = base_en_reg[`BIT_GLOBAL_EN];
  assign ext_pin0_irq_wake_en = base_en_reg[`BIT_EXT0_EN];
  assign ext_pin1_irq_wake_en = base_en_reg[`BIT_EXT1_EN];
  assign timer0_irq_en        = base_en_reg[`BIT_TIMER0_EN];
  assign timer1_irq_en        = base_en_reg[`BIT_TIMER1_EN];
  assign timer2_irq_en        = base_en_reg[`BIT_TIMER2_EN];
  assign serial1_irq_en       = base_en_reg[`BIT_SERIAL1_EN];
  assign pwm_ch0_irq_en       = pwm_en_reg[`BIT_PWM0_EN];
  assign pwm_ch1_irq_en       = pwm_en_reg[`BIT_PWM1_EN];

  // Pins are asynchronous; synchronise before edge detection
  sync2 #(
    .WIDTH(2)
  ) u_pin_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({ext_pin1_n, ext_pin0_n}),
    .sync_out (pin_sync)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_reg <= 2'h3;
    end else begin
      pin_prev_reg <= pin_sync;
    end
  end

  // Falling edge of an active-low pin is the event
  assign pin_fall = pin_prev_reg & ~pin_sync;

  always_comb begin
    src_event                = '0;
    src_event[`SRC_EXT0]     = pin_fall[0];
    src_event[`SRC_EXT1]     = pin_fall[1];
    src_event[`SRC_TIMER0]   = periph_evt.timer0;
    src_event[`SRC_TIMER1]   = periph_evt.timer1;
    src_event[`SRC_TIMER2]   = periph_evt.timer2;
    src_event[`SRC_SERIAL1]  = periph_evt.serial1;
    src_event[`SRC_PWM0]     = periph_evt.pwm0;
    src_event[`SRC_PWM1]     = periph_evt.pwm1;
  end

  always_comb begin
    src_enable               = '0;
    src_enable[`SRC_EXT0]    = ext_pin0_irq_wake_en;
    src_enable[`SRC_EXT1]    = ext_pin1_irq_wake_en;
    src_enable[`SRC_TIMER0]  = timer0_irq_en;
    src_enable[`SRC_TIMER1]  = timer1_irq_en;
    src_enable[`SRC_TIMER2]  = timer2_irq_en;
    src_enable[`SRC_SERIAL1] = serial1_irq_en;
    src_enable[`SRC_PWM0]    = pwm_ch0_irq_en && pwm_group_irq_en;
    src_enable[`SRC_PWM1]    = pwm_ch1_irq_en && pwm_group_irq_en;
  end

  assign pending = global_irq_en ? (flag_reg & src_enable) : '0;

  // Wake does not look at the global enable
  assign wake_req = (flag_reg[`SRC_EXT0] && ext_pin0_irq_wake_en) ||
                    (flag_reg[`SRC_EXT1] && ext_pin1_irq_wake_en);

  prio_select #(
    .N    (NSRC),
    .IDX_W(3)
  ) u_prio_select (
    .pending(pending),
    .prio   (prio_reg),
    .any    (sel_any),
    .idx    (sel_idx),
    .level  (sel_level)
  );

  // Highest level now in service
  always_comb begin
    cur_any   = |active_reg;
    cur_level = 2'h0;
    for (int l = 0; l < 4; l++) begin
      if (active_reg[l]) begin
        cur_level = 2'(l);
      end
    end
  end

  assign preempt_ok = sel_any && (!cur_any || sel_level > cur_level);

  always_comb begin
    case (sel_idx)
      3'(`SRC_EXT0):    sel_num = `VEC_EXT0;
      3'(`SRC_TIMER0):  sel_num = `VEC_TIMER0;
      3'(`SRC_EXT1):    sel_num = `VEC_EXT1;
      3'(`SRC_TIMER1):  sel_num = `VEC_TIMER1;
      3'(`SRC_SERIAL1): sel_num = `VEC_SERIAL1;
      3'(`SRC_TIMER2):  sel_num = `VEC_TIMER2;
      default:          sel_num = `VEC_PWM;
    endcase
  end

  // Request is registered; the cycle after a take is blanked so a stale
  // request is never offered while the in-service state catches up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_req      <= '0;
      taken_idx_reg <= 3'h0;
    end else begin
      core_req.valid <= preempt_ok && !(core_ack && core_req.valid);
      core_req.num   <= sel_num;
      core_req.level <= sel_level;
      if (preempt_ok) begin
        taken_idx_reg <= sel_idx;
      end
    end
  end

  // In-service levels: return pops the top, take pushes the new level
  always_comb begin
    active_next = active_reg;
    if (core_ret && cur_any) begin
      active_next[cur_level] = 1'b0;
    end
    if (core_ack && core_req.valid) begin
      active_next[core_req.level] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_reg <= 4'h0;
    end else begin
      active_reg <= active_next;
    end
  end

  // Flags: software and hardware clears, then events set; set wins
  always_comb begin
    flag_next = flag_reg;
    if (wr_access && paddr == `OFF_FLAG_STATUS) begin
      flag_next = flag_next & ~pwdata[NSRC-1:0];
    end
    if (core_ack && core_req.valid) begin
      flag_next[taken_idx_reg] = flag_next[taken_idx_reg] & ~HW_CLEAR_BITS[taken_idx_reg];
    end
    flag_next = flag_next | src_event;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= `FLAG_RESET;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Summary interrupt for the system, separate from the core path
  assign irq = |(flag_reg & mask_reg);

  // Enable bytes; reserved bits stay zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      base_en_reg <= `BASE_EN_RESET;
    end else if (wr_access && paddr == `OFF_BASE_EN) begin
      base_en_reg <= pwdata[7:0] & `BASE_EN_RW_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_en_reg <= `PWM_EN_RESET;
    end else if (wr_access && paddr == `OFF_PWM_EN) begin
      pwm_en_reg <= pwdata[7:0] & `PWM_EN_RW_MASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= `MASK_RESET;
    end else if (wr_access && paddr == `OFF_FLAG_MASK) begin
      mask_reg <= pwdata[NSRC-1:0];
    end
  end

  // Priority change takes effect on the next arbitration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prio_reg <= `PRIORITY_RESET;
    end else if (wr_access && paddr == `OFF_PRIORITY) begin
      prio_reg <= pwdata[2*NSRC-1:0];
    end
  end

  // Read mux
  always_comb begin
    rd_value = 32'h0000_0000;
    addr_hit = 1'b1;
    if (paddr == `OFF_PWM_EN) begin
      rd_value[7:0] = pwm_en_reg;
    end else if (paddr == `OFF_BASE_EN) begin
      rd_value[7:0] = base_en_reg;
    end else if (paddr == `OFF_FLAG_STATUS) begin
      rd_value[NSRC-1:0] = flag_reg;
    end else if (paddr == `OFF_FLAG_MASK) begin
      rd_value[NSRC-1:0] = mask_reg;
    end else if (paddr == `OFF_PRIORITY) begin
      rd_value[2*NSRC-1:0] = prio_reg;
    end else if (paddr == `OFF_IN_SERVICE) begin
      rd_value[3:0] = active_reg;
    end else begin
      addr_hit = 1'b0;
    end
  end

  // Data captured in setup so the answer comes from flops with no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_phase) begin
      prdata  <= pwrite ? 32'h0000_0000 : rd_value;
      pslverr <= !addr_hit;
    end else if (!psel) begin
      pslverr <= 1'b0;
    end
  end

endmodule

// ---- common/irq_gate_cfg.svh ----
`ifndef IRQ_GATE_CFG_SVH
`define IRQ_GATE_CFG_SVH

// Byte addresses on the register bus
`define OFF_PWM_EN        8'h84
`define OFF_BASE_EN       8'hA8
`define OFF_FLAG_STATUS   8'hC0
`define OFF_FLAG_MASK     8'hC4
`define OFF_PRIORITY      8'hC8
`define OFF_IN_SERVICE    8'hCC

// Base enable byte fields
`define BIT_GLOBAL_EN     7
`define BIT_TIMER2_EN     5
`define BIT_SERIAL1_EN    4
`define BIT_TIMER1_EN     3
`define BIT_EXT1_EN       2
`define BIT_TIMER0_EN     1
`define BIT_EXT0_EN       0
`define BASE_EN_RW_MASK   8'hBF
`define BASE_EN_RESET     8'h00

// PWM channel enable byte fields
`define BIT_PWM1_EN       1
`define BIT_PWM0_EN       0
`define PWM_EN_RW_MASK    8'h03
`define PWM_EN_RESET      8'h00

// Source positions in the flag, mask and priority layout
`define SRC_EXT0          0
`define SRC_TIMER0        1
`define SRC_EXT1          2
`define SRC_TIMER1        3
`define SRC_SERIAL1       4
`define SRC_TIMER2        5
`define SRC_PWM0          6
`define SRC_PWM1          7

// Flags cleared by the core taking the request
`define HW_CLEAR_MASK     8'h2F
`define FLAG_RESET        8'h00
`define MASK_RESET        8'h00
`define PRIORITY_RESET    16'h0000

// Vector numbers handed to the core
`define VEC_EXT0          4'h0
`define VEC_TIMER0        4'h1
`define VEC_EXT1          4'h2
`define VEC_TIMER1        4'h3
`define VEC_SERIAL1       4'h4
`define VEC_TIMER2        4'h5
`define VEC_PWM           4'hE

`endif

// ---- common/irq_gate_pkg.sv ----
package irq_gate_pkg;

  // Same-clock event pulses from the peripherals
  typedef struct packed {
    logic pwm1;
    logic pwm0;
    logic timer2;
    logic serial1;
    logic timer1;
    logic timer0;
  } periph_evt_t;

  // Request presented to the core sequencer
  typedef struct packed {
    logic       valid;
    logic [3:0] num;
    logic [1:0] level;
  } core_req_t;

endpackage

// ---- rtl/sync2.sv ----
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 2
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  // Reset to all ones: idle level of active-low pins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_reg <= '1;
      sync_out   <= '1;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule

// ---- rtl/prio_select.sv ----
`timescale 1ns/1ps
module prio_select #(
  parameter int N     = 8,
  parameter int IDX_W = 3
) (
  input  wire logic [N-1:0]   pending,
  input  wire logic [2*N-1:0] prio,
  output logic                any,
  output logic [IDX_W-1:0]    idx,
  output logic [1:0]          level
);

  // Highest level wins; lowest index breaks a tie
  always_comb begin
    any   = 1'b0;
    idx   = '0;
    level = 2'h0;
    for (int i = N - 1; i >= 0; i--) begin
      if (pending[i] && (!any || prio[2*i +: 2] >= level)) begin
        any   = 1'b1;
        idx   = IDX_W'(i);
        level = prio[2*i +: 2];
      end
    end
  end

endmodule

// ---- tb/irq_gate_chk.sv ----
`timescale 1ns/1ps
module irq_gate_chk
  import irq_gate_pkg::*;
#(
  parameter int ADDR_W = 8
) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       pwdata,
  input wire logic              pslverr,
  input wire logic              ext_pin0_n,
  input wire logic              pwm_group_irq_en,
  input wire logic              core_ack,
  input wire logic              core_ret,
  input wire core_req_t         core_req,
  input wire logic              wake_req
);
  logic [7:0] en_sh;
  logic [3:0] svc_sh;
  logic [3:0] pop;
  logic [1:0] top;
  always_comb begin
    top = 2'h0;
    for (int i = 0; i < 4; i++) begin
      if (svc_sh[i]) top = 2'(i);
    end
  end
  assign pop = (core_ret && svc_sh != 4'h0) ? 4'h1 << top : 4'h0;
  // Shadow copies, so gating is judged from bus traffic and the core handshake alone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_sh <= 8'h00;
    end else if (psel && penable && pwrite && paddr == 8'hA8) begin
      en_sh <= pwdata[7:0];
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      svc_sh <= 4'h0;
    end else begin
      svc_sh <= (svc_sh & ~pop) | ((core_ack && core_req.valid) ? 4'h1 << core_req.level : 4'h0);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_pin0_armed;
    $fell(ext_pin0_n) && en_sh[0];
  endsequence
  property p_pwm_gate;
    core_req.valid && core_req.num == 4'hE |-> $past(pwm_group_irq_en);
  endproperty
  a_pwm_gate: assert property (p_pwm_gate) else $error("pwm request without group enable");
  property p_pin_off;
    !en_sh[0] && !en_sh[2] |-> !wake_req;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("wake with pins disabled");
  property p_pin0_wake;
    s_pin0_armed |-> ##[1:4] wake_req;
  endproperty
  a_pin0_wake: assert property (p_pin0_wake) else $error("no wake from pin 0");
  property p_wake_noglb;
    s_pin0_armed ##0 !en_sh[7] |-> ##[1:4] wake_req;
  endproperty
  a_wake_noglb: assert property (p_wake_noglb) else $error("wake blocked by global enable");
  property p_global_off;
    !en_sh[7] |=> !core_req.valid;
  endproperty
  a_global_off: assert property (p_global_off) else $error("request with global enable off");
  property p_level_gate;
    core_req.valid |-> $past(svc_sh) == 4'h0 || core_req.level > $past(top);
  endproperty
  a_level_gate: assert property (p_level_gate) else $error("request not above level in service");
  property p_take_drop;
    core_ack && core_req.valid |=> !core_req.valid;
  endproperty
  a_take_drop: assert property (p_take_drop) else $error("request held after take");
  property p_slverr;
    psel && penable && !(paddr inside {8'h84, 8'hA8, 8'hC0, 8'hC4, 8'hC8, 8'hCC}) |-> pslverr;
  endproperty
  a_slverr: assert property (p_slverr) else $error("unmapped access without error");
endmodule
bind interrupt_enable_wakeup_gating irq_gate_chk #(.ADDR_W(ADDR_W)) i_irq_gate_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pslverr(pslverr), .ext_pin0_n(ext_pin0_n), .pwm_group_irq_en(pwm_group_irq_en),
  .core_ack(core_ack), .core_ret(core_ret), .core_req(core_req), .wake_req(wake_req)
);

// ---- tb/irq_core_model.sv ----
`timescale 1ns/1ps
module irq_core_model
  import irq_gate_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire core_req_t core_req,
  input  wire logic      take_en,
  input  wire logic      ret_go,
  output logic           core_ack,
  output logic           core_ret
);
  // Slow core: take_en low leaves requests pending
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ack <= 1'h0;
    end else begin
      core_ack <= core_req.valid & take_en & ~core_ack;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_ret <= 1'h0;
    end else begin
      core_ret <= ret_go & ~core_ret;
    end
  end
endmodule

// ---- tb/interrupt_enable_wakeup_gating_tb.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin fails++; \
  $display("wrong value %s exp %0h got %0h", n, e, g); end end
module interrupt_enable_wakeup_gating_tb
  import irq_gate_pkg::*;
;
  logic        pclk = 1'h0;
  logic        presetn = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin0_n = 1'h1;
  logic        pin1_n = 1'h1;
  periph_evt_t evt = '0;
  logic        grp = 1'h0;
  logic        take_en = 1'h0;
  logic        ret_go = 1'h0;
  logic        core_ack;
  logic        core_ret;
  core_req_t   core_req;
  logic        wake_req;
  logic        irq;
  logic [31:0] q;
  logic        err;
  int          fails = 0;
  int          n_tests = 0;
  int          cyc = 0;
  initial forever #12.5 pclk = ~pclk;
  interrupt_enable_wakeup_gating i_interrupt_enable_wakeup_gating (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ext_pin0_n(pin0_n),
    .ext_pin1_n(pin1_n), .periph_evt(evt), .pwm_group_irq_en(grp), .core_ack(core_ack),
    .core_ret(core_ret), .core_req(core_req), .wake_req(wake_req), .irq(irq)
  );
  irq_core_model i_irq_core_model (
    .pclk(pclk), .presetn(presetn), .core_req(core_req), .take_en(take_en), .ret_go(ret_go),
    .core_ack(core_ack), .core_ret(core_ret)
  );
  task automatic summarize();
    $display("checks %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fails++;
      summarize();
    end
  end
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'h1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    q = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    `CHK($sformatf("reg %h", a), e, q)
  endtask
  // Wait covers flag, offer and a take by the core model
  task automatic ev(input periph_evt_t v);
    evt <= v;
    @(posedge pclk);
    evt <= '0;
    repeat (6) @(posedge pclk);
  endtask
  task automatic ret1();
    ret_go <= 1'h1;
    @(posedge pclk);
    ret_go <= 1'h0;
    repeat (6) @(posedge pclk);
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    rdchk(8'h84, 32'h0);
    rdchk(8'hA8, 32'h0);
    apb(1'h1, 8'hA8, 32'hFF);
    rdchk(8'hA8, 32'hBF);
    apb(1'h1, 8'h84, 32'hFF);
    rdchk(8'h84, 32'h3);
    rdchk(8'h10, 32'h0);
    `CHK("pslverr", 1'h1, err)
    apb(1'h1, 8'hA8, 32'h3F);
    ev(6'h3F);
    rdchk(8'hC0, 32'hFA);
    `CHK("req", 1'h0, core_req.valid)
    `CHK("irq", 1'h0, irq)
    apb(1'h1, 8'hC4, 32'h2);
    `CHK("irq", 1'h1, irq)
    apb(1'h1, 8'hC0, 32'h2);
    `CHK("irq", 1'h0, irq)
    rdchk(8'hC0, 32'hF8);
    apb(1'h1, 8'hC0, 32'hFF);
    apb(1'h1, 8'h84, 32'h2);
    apb(1'h1, 8'hA8, 32'h80);
    grp <= 1'h1;
    ev(6'h10);
    `CHK("req", 1'h0, core_req.valid)
    grp <= 1'h0;
    ev(6'h20);
    `CHK("req", 1'h0, core_req.valid)
    grp <= 1'h1;
    repeat (3) @(posedge pclk);
    `CHK("req", 1'h1, core_req.valid)
    `CHK("num", 4'hE, core_req.num)
    `CHK("level", 2'h0, core_req.level)
    grp <= 1'h0;
    apb(1'h1, 8'hC0, 32'hC0);
    apb(1'h1, 8'hA8, 32'h0);
    pin0_n <= 1'h0;
    repeat (6) @(posedge pclk);
    `CHK("wake", 1'h0, wake_req)
    rdchk(8'hC0, 32'h1);
    pin0_n <= 1'h1;
    apb(1'h1, 8'hC0, 32'h1);
    apb(1'h1, 8'hA8, 32'h1);
    pin0_n <= 1'h0;
    repeat (6) @(posedge pclk);
    `CHK("wake", 1'h1, wake_req)
    `CHK("req", 1'h0, core_req.valid)
    apb(1'h1, 8'hA8, 32'h81);
    repeat (2) @(posedge pclk);
    `CHK("req", 1'h1, core_req.valid)
    `CHK("num", 4'h0, core_req.num)
    pin0_n <= 1'h1;
    apb(1'h1, 8'hC0, 32'h1);
    apb(1'h1, 8'hA8, 32'h4);
    pin1_n <= 1'h0;
    repeat (6) @(posedge pclk);
    `CHK("wake", 1'h1, wake_req)
    pin1_n <= 1'h1;
    apb(1'h1, 8'hC0, 32'h4);
    apb(1'h1, 8'hC8, 32'h184);
    apb(1'h1, 8'hA8, 32'h9A);
    take_en <= 1'h1;
    ev(6'h01);
    rdchk(8'hCC, 32'h2);
    ev(6'h04);
    rdchk(8'hCC, 32'h2);
    `CHK("req", 1'h0, core_req.valid)
    ev(6'h02);
    rdchk(8'hCC, 32'h6);
    ret1();
    rdchk(8'hCC, 32'h2);
    ret1();
    rdchk(8'hCC, 32'h2);
    apb(1'h1, 8'hC0, 32'h10);
    ret1();
    rdchk(8'hCC, 32'h0);
    summarize();
  end
endmodule
